// ### rmt_tuning_ctrl.sv
// Notes on behaviour
// - Bit 6 puts Miller filter in fast mode
// - Bit 5 with select 1100b delays signal output
// - Bit 5 clear: no adjustable output delay
// - Bit 4 stops parity generation and checking
// - Bypassed parity bit passed on as data
// - Bit 3 widens clock-recovery loop bandwidth
// - Bit 2 clear: corner chosen from mode
// - Corner field: 106/212/424/848 kHz spectra
//
// Register access over APB was decided locally.
`timescale 1ns/10ps
`default_nettype none

module rmt_tuning_ctrl #(
    parameter int ADDR_W = 20
) (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    clk_en,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output logic [31:0]                  prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [3:0]              signal_out_select,
    input  wire logic [6:0]              transmit_bit_phase,
    input  wire logic [1:0]              response_wait,
    input  wire logic                    signal_out_raw,
    output logic                         signal_output_pin,
    input  wire rmt_pkg::rmt_corner_type rx_auto_corner,
    output rmt_pkg::rmt_corner_type      highpass_corner_select,
    output logic                         miller_fast_filter,
    output logic                         wide_clock_recovery_loop,
    input  wire logic [7:0]              tx_byte,
    input  wire logic                    tx_byte_valid,
    output logic                         tx_parity_bit,
    output logic                         tx_parity_insert,
    input  wire rmt_pkg::rmt_rx_word_type rx_word_in,
    input  wire logic                    rx_word_valid,
    output rmt_pkg::rmt_rx_word_type     rx_word_out,
    output logic                         rx_word_out_valid,
    output logic                         rx_parity_error
);
    import rmt_pkg::*;

    rmt_tuning_type           tuning;
    logic [DLY_DEPTH-1:0]     dly_line;
    logic                     hit;
    logic                     wr_en;
    logic                     delay_active;

    // Odd parity as used on the contactless byte frame
    function automatic logic odd_parity(input logic [7:0] b);
        odd_parity = ~(^b);
    endfunction

    // Delay tap: bit phase plus whole bits of response wait, clamped
    function automatic logic [8:0] dly_tap(input logic [6:0] ph,
                                          input logic [1:0] rw);
        logic [15:0] sum;
        sum = 16'(ph) + 16'(rw) * 16'(BIT_CYCLES);
        if (sum > 16'(DLY_DEPTH - 1))
            dly_tap = 9'(DLY_DEPTH - 1);
        else
            dly_tap = sum[8:0];
    endfunction

    // Bus decode; zero wait states, frozen with the clock enable
    assign hit     = (paddr == TUNING_ADDR[ADDR_W-1:0]);
    assign pready  = clk_en;
    assign pslverr = psel && penable && !hit;
    assign wr_en   = psel && penable && pwrite && hit && pstrb[0] && clk_en;

    // Read mux; reserved bit and upper bytes read as zero
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit) begin
            prdata[7:0] = tuning & TUNING_WMASK;
        end
    end

    // Tuning register; bit 7 ignores writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tuning <= TUNING_RESET;
        end else if (wr_en) begin
            tuning <= pwdata[7:0] & TUNING_WMASK;
        end
    end

    // Static tuning outputs
    assign miller_fast_filter       = tuning.miller_fast_filter;
    assign wide_clock_recovery_loop =
        tuning.wide_clock_recovery_loop;

    // Corner: manual field or automatic pick from the receive mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            highpass_corner_select <= CORNER_106K;
        end else if (clk_en) begin
            if (tuning.highpass_manual_override)
                highpass_corner_select <=
                    tuning.highpass_corner_select;
            else
                highpass_corner_select <= rx_auto_corner;
        end
    end

    // Delay only in the one select code that supports it
    assign delay_active = tuning.signal_out_delay_enable &&
                          (signal_out_select == SIGSEL_DELAYED);

    // Delay line runs whether or not the delay is on, so a switch-on shows real history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_line <= '0;
        end else if (clk_en) begin
            dly_line <= {dly_line[DLY_DEPTH-2:0], signal_out_raw};
        end
    end

    // Output pin: tapped line, or a single retiming flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            signal_output_pin <= 1'b0;
        end else if (clk_en) begin
            if (delay_active)
                signal_output_pin <=
                    dly_line[dly_tap(transmit_bit_phase,
                                     response_wait)];
            else
                signal_output_pin <= signal_out_raw;
        end
    end

    // Transmit parity; insertion withdrawn while bypassed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_parity_bit    <= 1'b0;
            tx_parity_insert <= 1'b0;
        end else if (clk_en) begin
            tx_parity_bit    <= tx_byte_valid && odd_parity(tx_byte) &&
                                !tuning.parity_bypass;
            tx_parity_insert <= tx_byte_valid &&
                                !tuning.parity_bypass;
        end
    end

    // Receive path: check parity, or pass the bit on as data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_word_out       <= '0;
            rx_word_out_valid <= 1'b0;
            rx_parity_error   <= 1'b0;
        end else if (clk_en) begin
            rx_word_out_valid <= rx_word_valid;
            if (rx_word_valid) begin
                rx_word_out.data <= rx_word_in.data;
                rx_word_out.parity <= tuning.parity_bypass &&
                                      rx_word_in.parity;
            end
            rx_parity_error <= rx_word_valid && !tuning.parity_bypass &&
                (rx_word_in.parity != odd_parity(rx_word_in.data));
        end
    end

    // Checks on the guarded behaviour
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Sampled reset in antecedents skips the release edge, where the
    // flops still show reset values while the inputs have moved on
    logic run_ok;
    assign run_ok = presetn && clk_en;

    sequence s_write_bit(int pos, logic v);
        wr_en && pwdata[pos] == v;
    endsequence

    sequence s_rx_bypassed;
        run_ok && rx_word_valid && tuning.parity_bypass;
    endsequence

    AST_FAST_FILTER: assert property (
        s_write_bit(FAST_POS, 1'b1) |=> miller_fast_filter)
        else $error("fast filter not set after write");

    AST_WIDE_LOOP: assert property (
        s_write_bit(WIDEBW_POS, 1'b0) |=> !wide_clock_recovery_loop)
        else $error("wide loop not cleared after write");

    AST_DELAY_OFF: assert property (
        run_ok && !tuning.signal_out_delay_enable
        |=> signal_output_pin == $past(signal_out_raw))
        else $error("output delayed while delay disabled");

    AST_DELAY_ON: assert property (
        run_ok && delay_active && transmit_bit_phase == 7'h05 &&
        response_wait == 2'h0
        |=> signal_output_pin == $past(dly_line[5]))
        else $error("output delay tap wrong");

    AST_TX_NO_PARITY: assert property (
        clk_en && tuning.parity_bypass |=> !tx_parity_insert)
        else $error("parity inserted while bypassed");

    AST_RX_NO_CHECK: assert property (
        s_rx_bypassed |=> !rx_parity_error && rx_word_out_valid)
        else $error("parity checked while bypassed");

    AST_RX_PASS_BIT: assert property (
        s_rx_bypassed |=> rx_word_out.parity == $past(rx_word_in.parity))
        else $error("parity bit not passed as data");

    AST_RX_CHECK: assert property (
        run_ok && rx_word_valid && !tuning.parity_bypass &&
        rx_word_in.parity == ^rx_word_in.data |=> rx_parity_error)
        else $error("bad parity not flagged");

    AST_AUTO_CORNER: assert property (
        run_ok && !tuning.highpass_manual_override
        |=> highpass_corner_select == $past(rx_auto_corner))
        else $error("auto corner not followed");

    AST_MANUAL_CORNER: assert property (
        run_ok && tuning.highpass_manual_override
        |=> highpass_corner_select == $past(tuning.highpass_corner_select))
        else $error("manual corner not applied");

    AST_RESERVED_ZERO: assert property (
        s_write_bit(RSVD_POS, 1'b1) |=> !tuning[RSVD_POS] && !prdata[7])
        else $error("reserved bit not zero");

    // Further checks: write paths, bypass side effects, freeze
    AST_FAST_CLEAR: assert property (
        s_write_bit(FAST_POS, 1'b0) |=> !miller_fast_filter)
        else $error("fast filter not cleared after write");

    AST_WIDE_SET: assert property (
        s_write_bit(WIDEBW_POS, 1'b1) |=> wide_clock_recovery_loop)
        else $error("wide loop not set after write");

    AST_SELECT_GATE: assert property (
        run_ok && tuning.signal_out_delay_enable &&
        signal_out_select != SIGSEL_DELAYED
        |=> signal_output_pin == $past(signal_out_raw))
        else $error("output delayed under another select code");

    AST_DELAY_LONG: assert property (
        run_ok && delay_active && transmit_bit_phase == 7'h05 &&
        response_wait == 2'h1
        |=> signal_output_pin == $past(dly_line[5 + BIT_CYCLES]))
        else $error("output delay tap wrong with response wait");

    AST_TX_PARITY: assert property (
        run_ok && tx_byte_valid && !tuning.parity_bypass
        |=> tx_parity_insert && tx_parity_bit != $past(^tx_byte))
        else $error("transmit parity wrong");

    AST_TX_BIT_LOW: assert property (
        clk_en && tuning.parity_bypass |=> !tx_parity_bit)
        else $error("parity bit driven while bypassed");

    AST_RX_DATA: assert property (
        run_ok && rx_word_valid
        |=> rx_word_out.data == $past(rx_word_in.data))
        else $error("received data not passed on");

    AST_RX_ZERO_PARITY: assert property (
        run_ok && rx_word_valid && !tuning.parity_bypass
        |=> !rx_word_out.parity)
        else $error("checked parity bit passed on");

    AST_RX_GOOD: assert property (
        run_ok && rx_word_valid && !tuning.parity_bypass &&
        rx_word_in.parity != ^rx_word_in.data |=> !rx_parity_error)
        else $error("good parity flagged");

    // Manual corner takes two steps: write, then the corner flop
    sequence s_manual_write;
        s_write_bit(MANUAL_POS, 1'b1) ##1 run_ok;
    endsequence

    AST_MANUAL_FIELD: assert property (
        s_manual_write
        |=> highpass_corner_select == $past(pwdata[CORNER_POS+:2], 2))
        else $error("written corner field not applied");

    AST_STROBE_HOLD: assert property (
        run_ok && psel && penable && pwrite && !pstrb[0]
        |=> $stable(tuning))
        else $error("write without low strobe changed register");

    // Clock enable low must leave every register where it was
    AST_FREEZE: assert property (
        presetn && !clk_en
        |=> $stable(tuning) && $stable(highpass_corner_select) &&
            $stable(signal_output_pin) && $stable(rx_word_out_valid))
        else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// ### rmt_pkg.sv
package rmt_pkg;

    // Register index and byte address on the word-aligned bus
    localparam logic [19:0] TUNING_INDEX = 20'h0630D;
    localparam logic [19:0] TUNING_ADDR  = 20'h18C34;

    // Field positions of the tuning register
    localparam int RSVD_POS     = 7;
    localparam int FAST_POS     = 6;
    localparam int DELAY_POS    = 5;
    localparam int PARITY_POS   = 4;
    localparam int WIDEBW_POS   = 3;
    localparam int MANUAL_POS   = 2;
    localparam int CORNER_POS   = 0;

    localparam logic [7:0] TUNING_RESET = 8'h00;
    localparam logic [7:0] TUNING_WMASK = 8'h7F;

    // Signal-output select code that the adjustable delay acts on
    localparam logic [3:0] SIGSEL_DELAYED = 4'hC;

    // Delay line geometry, in pclk cycles
    localparam int DLY_DEPTH  = 512;
    localparam int BIT_CYCLES = 96;

    // Receiver filter lower corner
    typedef enum logic [1:0] {
        CORNER_106K,
        CORNER_212K,
        CORNER_424K,
        CORNER_848K
    } rmt_corner_type;

    // Tuning register layout
    typedef struct packed {
        logic           reserved;
        logic           miller_fast_filter;
        logic           signal_out_delay_enable;
        logic           parity_bypass;
        logic           wide_clock_recovery_loop;
        logic           highpass_manual_override;
        rmt_corner_type highpass_corner_select;
    } rmt_tuning_type;

    // Received byte with its parity-position bit
    typedef struct packed {
        logic       parity;
        logic [7:0] data;
    } rmt_rx_word_type;

endpackage

// ### rmt_tuning_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module rmt_tuning_ctrl_tb_top;
    import rmt_pkg::*;
    typedef struct {
        logic [7:0]     wr;
        rmt_corner_type au;
        logic [7:0]     rd;
        logic           f;
        logic           w;
        rmt_corner_type c;
    } rmt_row_type;
    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [19:0]     paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic [3:0]      pstrb, sig_sel;
    logic [6:0]      bit_phase;
    logic [1:0]      resp_wait;
    logic            sig_raw, sig_pin, fast, wide, tx_valid, tx_bit, tx_ins;
    logic            rx_valid, rx_ovalid, rx_err, er, clk_en;
    logic [7:0]      tx_byte;
    rmt_corner_type  auto_c, corner;
    rmt_rx_word_type rx_in, rx_out;
    int              err_count, n_tests, n;
    // Write value, auto corner, readback, fast, wide, corner seen
    rmt_row_type rows [7] = '{
        '{8'hFF, CORNER_106K, 8'h7F, 1'b1, 1'b1, CORNER_848K},
        '{8'h44, CORNER_848K, 8'h44, 1'b1, 1'b0, CORNER_106K},
        '{8'h0D, CORNER_424K, 8'h0D, 1'b0, 1'b1, CORNER_212K},
        '{8'h06, CORNER_106K, 8'h06, 1'b0, 1'b0, CORNER_424K},
        '{8'h03, CORNER_212K, 8'h03, 1'b0, 1'b0, CORNER_212K},
        '{8'h00, CORNER_424K, 8'h00, 1'b0, 1'b0, CORNER_424K},
        '{8'h80, CORNER_848K, 8'h00, 1'b0, 1'b0, CORNER_848K}};

    rmt_tuning_ctrl rmt_tuning_ctrl_inst (.pclk(pclk), .presetn(presetn),
        .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .signal_out_select(sig_sel),
        .transmit_bit_phase(bit_phase), .response_wait(resp_wait),
        .signal_out_raw(sig_raw), .signal_output_pin(sig_pin),
        .rx_auto_corner(auto_c), .highpass_corner_select(corner),
        .miller_fast_filter(fast), .wide_clock_recovery_loop(wide),
        .tx_byte(tx_byte), .tx_byte_valid(tx_valid), .tx_parity_bit(tx_bit),
        .tx_parity_insert(tx_ins), .rx_word_in(rx_in),
        .rx_word_valid(rx_valid), .rx_word_out(rx_out),
        .rx_word_out_valid(rx_ovalid), .rx_parity_error(rx_err));

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One APB transfer; waits on pready, never on a fixed count
    task apb(input logic w, input logic [19:0] a, input logic [7:0] d,
             input logic [3:0] s);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            err_count++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Edges from a raw pulse until the pin shows it; bounded
    task lat(input logic [3:0] sel, input logic [7:0] r);
        apb(1'b1, TUNING_ADDR, r, 4'hF);
        sig_sel <= sel;
        repeat (520) @(posedge pclk);
        sig_raw <= 1'b1;
        for (n = 1; n < 700; n++) begin
            @(posedge pclk);
            sig_raw <= 1'b0;
            @(negedge pclk);
            if (sig_pin === 1'b1) break;
        end
        if (n == 700) begin
            err_count++;
            give_verdict();
        end
    endtask

    // Transmit and receive one byte together
    task par(input logic [7:0] r, input rmt_rx_word_type wi,
             input logic [1:0] etx, input logic [8:0] erx, input logic ee);
        apb(1'b1, TUNING_ADDR, r, 4'hF);
        @(posedge pclk);
        tx_byte <= wi.data;
        tx_valid <= 1'b1;
        rx_in <= wi;
        rx_valid <= 1'b1;
        @(posedge pclk);
        tx_valid <= 1'b0;
        rx_valid <= 1'b0;
        @(negedge pclk);
        chk("tx insert,bit", {30'h0, etx}, {30'h0, tx_ins, tx_bit});
        chk("rx word", {23'h0, erx}, {23'h0, rx_out});
        chk("rx error", {31'h0, ee}, {31'h0, rx_err});
        chk("rx valid", 32'h1, {31'h0, rx_ovalid});
        $display("parity test done");
    endtask

    initial begin
        {psel, penable, pwrite, sig_raw, tx_valid, rx_valid} = 6'h00;
        {paddr, pwdata, pstrb, sig_sel, tx_byte, rx_in} = '0;
        {bit_phase, resp_wait, err_count, n_tests} = '0;
        auto_c = CORNER_106K;
        clk_en = 1'b1;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TUNING_ADDR, 8'h00, 4'hF);
        chk("reset value", {24'h0, TUNING_RESET}, rd);
        $display("reset value test done");
        // Table of ordinary writes and what each must produce
        foreach (rows[i]) begin
            @(posedge pclk);
            auto_c <= rows[i].au;
            apb(1'b1, TUNING_ADDR, rows[i].wr, 4'hF);
            apb(1'b0, TUNING_ADDR, 8'h00, 4'hF);
            chk("readback", {24'h0, rows[i].rd}, rd);
            chk("fast filter", {31'h0, rows[i].f}, {31'h0, fast});
            chk("wide loop", {31'h0, rows[i].w}, {31'h0, wide});
            chk("corner", {30'h0, rows[i].c}, {30'h0, corner});
            $display("row %0d done", i);
        end
        // Refused writes: unmapped address and missing low strobe
        apb(1'b1, TUNING_ADDR + 20'h4, 8'h7F, 4'hF);
        chk("unmapped err", 32'h1, {31'h0, er});
        apb(1'b0, TUNING_ADDR + 20'h4, 8'h00, 4'hF);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, TUNING_ADDR, 8'h7F, 4'hE);
        apb(1'b0, TUNING_ADDR, 8'h00, 4'hF);
        chk("strobe ignored", 32'h0, rd);
        $display("refusal test done");
        par(8'h00, '{1'b0, 8'h03}, 2'b11, 9'h003, 1'b1);
        par(8'h00, '{1'b1, 8'h03}, 2'b11, 9'h003, 1'b0);
        par(8'h10, '{1'b1, 8'h03}, 2'b00, 9'h103, 1'b0);
        // Output delay: off, wrong select, shortest and two longer taps
        lat(4'hC, 8'h00);
        chk("delay off", 32'd1, n);
        lat(4'hE, 8'h20);
        chk("other select", 32'd1, n);
        lat(4'hC, 8'h20);
        chk("zero tap", 32'd2, n);
        @(posedge pclk);
        bit_phase <= 7'h05;
        lat(4'hC, 8'h20);
        chk("phase tap", 32'd7, n);
        @(posedge pclk);
        resp_wait <= 2'h1;
        lat(4'hC, 8'h20);
        chk("long tap", 32'd103, n);
        $display("delay test done");
        // Reset in mid-run clears the register and its outputs
        apb(1'b1, TUNING_ADDR, 8'h48, 4'hF);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TUNING_ADDR, 8'h00, 4'hF);
        chk("reset again", 32'h0, rd);
        chk("fast after reset", 32'h0, {31'h0, fast});
        $display("reset test done");
        // Clock enable low holds state and stalls the bus
        @(posedge pclk);
        clk_en <= 1'b0;
        auto_c <= CORNER_212K;
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        chk("pready stalled", 32'h0, {31'h0, pready});
        chk("corner frozen", {30'h0, CORNER_848K}, {30'h0, corner});
        @(posedge pclk);
        clk_en <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk("corner resumes", {30'h0, CORNER_212K}, {30'h0, corner});
        $display("clock enable test done");
        give_verdict();
    end
endmodule
`default_nettype wire
